//--- core/icd_pkg.sv
/*
  Shared constants and types for the ISA cycle control and DMA handshake block.
  Assumes a 40 MHz system clock and a separate oscillator clock for the timers.
*/
package icd_pkg;
  localparam int CLOCK_NS = 25;
  localparam int PREEMPT_NS = 4000;
  localparam int PREEMPT_CYC = (PREEMPT_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam int NCH = 8;
  localparam logic [7:0] CH_USED = 8'hef;
  localparam logic [7:0] DACK_RESET = 8'hff;
  localparam logic [3:0] LEN_ZW_16 = 4'h2;
  localparam logic [3:0] LEN_ZW_8 = 4'h3;
  localparam logic [3:0] LEN_STD_16 = 4'h3;
  localparam logic [3:0] LEN_STD_8 = 4'h6;
  localparam logic [15:0] TIMER_RELOAD = 16'hffff;
  localparam logic [7:0] HOLD_MAX = 8'hff;

  typedef enum logic [1:0] {
    ICD_MEM16 = 2'b00,
    ICD_IO16 = 2'b01,
    ICD_MEM8 = 2'b10,
    ICD_IO8 = 2'b11
  } icd_kind_type;

  typedef enum logic [0:0] {
    ICD_CYC_IDLE = 1'b0,
    ICD_CYC_BUSY = 1'b1
  } icd_cyc_type;

  typedef enum logic [0:0] {
    ICD_ARB_IDLE = 1'b0,
    ICD_ARB_GRANT = 1'b1
  } icd_arb_type;

  typedef struct packed {
    logic start;
    icd_kind_type kind;
  } icd_cycle_req_type;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } icd_sd_type;

  typedef struct packed {
    logic req_low;
    logic ack_high;
    logic compat;
  } icd_dma_cfg_type;
endpackage

//--- core/icd_top.sv
/*
  ISA cycle length control, reset drive, data lane drive, DMA request and
  acknowledge handshake with preemption, and oscillator-clocked timer counters.
  Assumes zero-wait and channel-ready are synchronous to the system clock;
  DMA requests and the PCI reset arrive asynchronously.
*/
// Function
// RQ1: Zero-wait 16-bit memory cycle takes two clocks
// RQ2: Zero-wait 8-bit cycle takes three clocks
// RQ3: Zero-wait ignored on 16-bit I/O cycles
// RQ4: Slave asserts zero-wait only after decoding
// RQ5: Channel-ready wait beats zero-wait same clock
// RQ6: Three timer counters run from oscillator
// RQ7: Reset drive follows PCI bus reset
// RQ8: Software can assert reset drive too
// RQ9: Software holds reset drive at least 1 us
// RQ10: Data lines float during reset
// RQ11: High byte on 15:8, low on 7:0
// RQ12: Request polarity chosen by command bit 6
// RQ13: Request edges treated as asynchronous
// RQ14: Requester holds request until acknowledged
// RQ15: Acknowledge polarity chosen by command bit 7
// RQ16: Slave qualifies acknowledge with I/O command
// RQ17: Master asserts ownership only after acknowledge
// RQ18: Preempt after 4 us outside compatible timing
// RQ19: Preempted transfer resumes on next win
// RQ20: PCI reset drives all acknowledges high
// RQ21: Master owns bus until it releases ownership
// RQ22: Requests synchronized before polarity and arbitration
`timescale 1ns/1ps
module icd_top
#(
  parameter logic [3:0] STD_LEN_16 = icd_pkg::LEN_STD_16,
  parameter logic [3:0] STD_LEN_8 = icd_pkg::LEN_STD_8,
  parameter logic [15:0] RELOAD = icd_pkg::TIMER_RELOAD
)
(
  // System clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Oscillator clock for the timers
  input wire logic osc_clock,
  // Cycle control
  input wire icd_pkg::icd_cycle_req_type cycle_req,
  input wire logic zero_wait_n,
  input wire logic chan_ready,
  output logic cycle_end,
  // Reset drive
  input wire logic pci_bus_reset_in,
  input wire logic clk_div_reset,
  output logic rst_drive,
  // Data lanes
  input wire icd_pkg::icd_sd_type sd_data,
  input wire logic drive_hi,
  input wire logic drive_lo,
  output icd_pkg::icd_sd_type sd_out,
  output logic sd_oe_hi,
  output logic sd_oe_lo,
  // DMA handshake
  input wire icd_pkg::icd_dma_cfg_type dma_cfg,
  input wire logic [7:0] dreq,
  output logic [7:0] dack,
  output logic dma_preempted,
  output logic dma_resumed,
  // Timer terminal counts
  output logic [2:0] timer_tick
);
  import icd_pkg::*;

  typedef struct packed {
    icd_cyc_type cyc;
    logic [3:0] cnt;
    icd_kind_type kind;
    logic zw_seen;
    logic cyc_end;
    logic [2:0] prst;
    logic pci_rst;
    logic rst_drive;
    icd_sd_type sd_out;
    logic sd_oe_hi;
    logic sd_oe_lo;
    logic [7:0] req_s1;
    logic [7:0] req_s2;
    logic [7:0] req_s3;
    logic [7:0] req_q;
    icd_arb_type arb;
    logic [2:0] owner;
    logic [7:0] ack_act;
    logic [7:0] dack;
    logic [7:0] hold;
    logic [7:0] preempted;
    logic preempt_evt;
    logic resume_evt;
    logic [2:0] tk_s1;
    logic [2:0] tk_s2;
    logic [2:0] tk_s3;
    logic [2:0] tk_q;
    logic [2:0] tick;
  } icd_state_type;

  typedef struct packed {
    logic [2:0][15:0] tcnt;
    logic [2:0] ttog;
  } icd_osc_type;

  icd_state_type st;
  icd_state_type next_st;
  icd_osc_type ost;
  icd_osc_type next_ost;
  logic [7:0] pend;
  logic [7:0] cand;
  logic [3:0] target;

  function automatic logic [2:0] icd_first(input logic [7:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--)
    begin
      if (v[i])
        idx = 3'(i);
    end
    return idx;
  endfunction

  // RQ6 Oscillator timer counters
  always_comb
  begin
    next_ost = ost;
    for (int i = 0; i < 3; i++)
    begin
      if (ost.tcnt[i] == 16'h0000)
      begin
        next_ost.tcnt[i] = RELOAD;
        next_ost.ttog[i] = ~ost.ttog[i];
      end
      else
        next_ost.tcnt[i] = ost.tcnt[i] - 16'h0001;
    end
  end

  always_ff @(posedge osc_clock or negedge resetn)
  begin
    if (!resetn)
      ost <= '0;
    else
      ost <= next_ost;
  end

  always_comb
  begin
    next_st = st;
    next_st.cyc_end = 1'b0;
    next_st.preempt_evt = 1'b0;
    next_st.resume_evt = 1'b0;
    next_st.tick = 3'h0;
    pend = 8'h00;
    cand = 8'h00;
    target = 4'h0;
    // RQ7 PCI reset synchronized into the clock domain
    next_st.prst = {st.prst[1:0], pci_bus_reset_in};
    if (st.prst[1] == st.prst[2])
      next_st.pci_rst = st.prst[2];
    // RQ8 Software reset drive joins PCI reset
    next_st.rst_drive = next_st.pci_rst | clk_div_reset;
    // RQ10 Lanes float while reset is driven
    next_st.sd_oe_hi = drive_hi & ~next_st.rst_drive;
    next_st.sd_oe_lo = drive_lo & ~next_st.rst_drive;
    // RQ11 Byte lanes kept in place
    next_st.sd_out.hi = sd_data.hi;
    next_st.sd_out.lo = sd_data.lo;

    case (st.cyc)
      ICD_CYC_IDLE:
      begin
        if (cycle_req.start)
        begin
          next_st.cyc = ICD_CYC_BUSY;
          next_st.cnt = 4'h1;
          next_st.kind = cycle_req.kind;
          next_st.zw_seen = 1'b0;
        end
      end
      ICD_CYC_BUSY:
      begin
        // RQ3 RQ5 Zero-wait taken only off 16-bit I/O and without wait
        if (!zero_wait_n && chan_ready && st.kind != ICD_IO16)
          next_st.zw_seen = 1'b1;
        // RQ1 RQ2 Shortened lengths
        if (next_st.zw_seen)
          target = (st.kind == ICD_MEM16) ? LEN_ZW_16 : LEN_ZW_8;
        else
          target = (st.kind[1] == 1'b0) ? STD_LEN_16 : STD_LEN_8;
        // RQ5 Channel-ready wait stretches the cycle
        if (st.cnt >= target && chan_ready)
        begin
          next_st.cyc = ICD_CYC_IDLE;
          next_st.cyc_end = 1'b1;
        end
        else if (chan_ready && st.cnt != 4'hf)
          next_st.cnt = st.cnt + 4'h1;
      end
      default:
        next_st.cyc = ICD_CYC_IDLE;
    endcase

    // RQ13 RQ22 Request synchronizers, change counts when stages agree
    next_st.req_s1 = dreq;
    next_st.req_s2 = st.req_s1;
    next_st.req_s3 = st.req_s2;
    for (int i = 0; i < NCH; i++)
    begin
      if (st.req_s2[i] == st.req_s3[i])
        next_st.req_q[i] = st.req_s3[i];
    end
    // RQ12 Polarity correction
    pend = (st.req_q ^ {NCH{dma_cfg.req_low}}) & CH_USED;

    case (st.arb)
      ICD_ARB_IDLE:
      begin
        cand = pend & ~st.preempted;
        if (cand == 8'h00)
          cand = pend;
        if (cand != 8'h00)
        begin
          next_st.arb = ICD_ARB_GRANT;
          next_st.owner = icd_first(cand);
          next_st.ack_act = 8'h01 << icd_first(cand);
          next_st.hold = 8'h00;
          // RQ19 Resume a preempted channel
          if (st.preempted[icd_first(cand)])
          begin
            next_st.resume_evt = 1'b1;
            next_st.preempted[icd_first(cand)] = 1'b0;
          end
        end
      end
      ICD_ARB_GRANT:
      begin
        if (st.hold != HOLD_MAX)
          next_st.hold = st.hold + 8'h01;
        // RQ14 Grant ends when the requester withdraws
        if (!pend[st.owner])
        begin
          next_st.arb = ICD_ARB_IDLE;
          next_st.ack_act = 8'h00;
        end
        // RQ18 Preempt after the hold time
        else if (!dma_cfg.compat && (pend & ~st.ack_act) != 8'h00 && st.hold >= 8'(PREEMPT_CYC - 1))
        begin
          next_st.arb = ICD_ARB_IDLE;
          next_st.ack_act = 8'h00;
          next_st.preempted[st.owner] = 1'b1;
          next_st.preempt_evt = 1'b1;
        end
      end
      default:
        next_st.arb = ICD_ARB_IDLE;
    endcase

    // RQ20 PCI reset clears the handshake
    if (next_st.pci_rst)
    begin
      next_st.arb = ICD_ARB_IDLE;
      next_st.ack_act = 8'h00;
      next_st.preempted = 8'h00;
      next_st.preempt_evt = 1'b0;
      next_st.resume_evt = 1'b0;
      next_st.dack = DACK_RESET;
    end
    // RQ15 Acknowledge polarity
    else
      next_st.dack = dma_cfg.ack_high ? next_st.ack_act : ~next_st.ack_act;

    // Timer toggles crossed from the oscillator domain
    next_st.tk_s1 = ost.ttog;
    next_st.tk_s2 = st.tk_s1;
    next_st.tk_s3 = st.tk_s2;
    for (int i = 0; i < 3; i++)
    begin
      if (st.tk_s2[i] == st.tk_s3[i] && st.tk_s3[i] != st.tk_q[i])
      begin
        next_st.tk_q[i] = st.tk_s3[i];
        next_st.tick[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      st <= '0;
      st.dack <= DACK_RESET;
    end
    else
      st <= next_st;
  end

  assign cycle_end = st.cyc_end;
  assign rst_drive = st.rst_drive;
  assign sd_out = st.sd_out;
  assign sd_oe_hi = st.sd_oe_hi;
  assign sd_oe_lo = st.sd_oe_lo;
  assign dack = st.dack;
  assign dma_preempted = st.preempt_evt;
  assign dma_resumed = st.resume_evt;
  assign timer_tick = st.tick;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // RQ1 Two-clock memory cycle
  a_zw_mem16_len: assert property ((st.cyc == ICD_CYC_BUSY && st.kind == ICD_MEM16 && st.zw_seen && st.cnt == 4'h2 && chan_ready) |=> cycle_end) else $error("16-bit zero-wait cycle not two clocks"); // RQ1
  // RQ2 Three-clock 8-bit cycle
  a_zw_8bit_len: assert property ((st.cyc == ICD_CYC_BUSY && st.kind[1] && st.zw_seen && st.cnt == 4'h2) |=> !cycle_end) else $error("8-bit zero-wait cycle ended early"); // RQ2
  // RQ3 No zero-wait on 16-bit I/O
  a_io16_no_zw: assert property ((st.cyc == ICD_CYC_BUSY && st.kind == ICD_IO16) |-> !st.zw_seen) else $error("Zero-wait taken on 16-bit I/O"); // RQ3
  // RQ5 Wait holds the cycle open
  a_chrdy_wins: assert property ((st.cyc == ICD_CYC_BUSY && !chan_ready) |=> !cycle_end) else $error("Cycle ended during wait"); // RQ5
  // RQ7 Reset drive follows PCI reset
  a_rst_pci: assert property (st.pci_rst |-> rst_drive) else $error("Reset drive missing under PCI reset"); // RQ7
  // RQ8 Software reset drive
  a_rst_sw: assert property (clk_div_reset |=> rst_drive) else $error("Software reset drive missing"); // RQ8
  // RQ10 Lanes float in reset
  a_sd_float: assert property (rst_drive |-> !sd_oe_hi && !sd_oe_lo) else $error("Data lanes driven in reset"); // RQ10
  // RQ20 Acknowledges high in reset
  a_dack_reset: assert property (st.pci_rst |-> dack == DACK_RESET) else $error("Acknowledge not high in reset"); // RQ20
  // RQ15 Granted channel shows active level
  a_ack_polarity: assert property ((st.arb == ICD_ARB_GRANT && !st.pci_rst && $stable(dma_cfg.ack_high)) |-> dack[st.owner] == dma_cfg.ack_high) else $error("Acknowledge level wrong"); // RQ15
  // RQ18 Preemption only after hold time
  a_preempt_time: assert property (st.preempt_evt |-> $past(st.hold) >= 8'(PREEMPT_CYC - 1) && !$past(dma_cfg.compat)) else $error("Preempted too early"); // RQ18

  c_zw_short: cover property (st.cyc_end && st.zw_seen);
  c_preempt: cover property (st.preempt_evt);
  c_resume: cover property (st.resume_evt);
  c_tick: cover property (timer_tick != 3'h0);
endmodule // icd_top

//--- verif/icd_dma_peer.sv
/*
  Far-side DMA requester model: raises requests for the bench.
  Assumes the bench sets want per channel and the device drives dack.
*/
`timescale 1ns/1ps
module icd_dma_peer
(
  // Clock
  input wire logic clock,
  // Bench side
  input wire logic [7:0] want,
  input wire logic io_cmd,
  input wire icd_pkg::icd_dma_cfg_type dma_cfg,
  // Device side
  input wire logic [7:0] dack,
  output logic [7:0] dreq,
  // Far-side view for the bench
  output logic [7:0] sel,
  output logic [7:0] owned
);
  import icd_pkg::*;
  logic [7:0] held = 8'h00;
  logic [7:0] acked;
  assign acked = dma_cfg.ack_high ? dack : ~dack;
  // slave selected only with an I/O command
  assign sel = acked & {8{io_cmd}};
  // ownership one clock after acknowledge, dropped when acknowledge or want falls
  always @(posedge clock)
  begin
    owned <= acked & want;
  end
  always @(posedge clock)
  begin
    held <= want | (held & ~acked);
  end
  assign dreq = (want | held) ^ {8{dma_cfg.req_low}};
endmodule // icd_dma_peer

//--- verif/icd_top_test.sv
/*
  Self-checking bench for cycle length, reset drive, data lanes, DMA handshake and timers.
  Assumes the requester model icd_dma_peer and a fast timer reload.
*/
`timescale 1ns/1ps
module icd_top_test;
  import icd_pkg::*;
  logic clock = 1'b0;
  logic osc_clock = 1'b0;
  logic resetn = 1'b0;
  icd_cycle_req_type cycle_req = '0;
  logic zero_wait_n = 1'b1;
  logic chan_ready = 1'b1;
  logic pci_bus_reset_in = 1'b0;
  logic clk_div_reset = 1'b0;
  icd_sd_type sd_data = '0;
  logic drive_hi = 1'b0;
  logic drive_lo = 1'b0;
  icd_dma_cfg_type dma_cfg = '0;
  logic [7:0] want = 8'h00;
  logic io_cmd = 1'b0;
  logic [7:0] sel, owned;
  logic cycle_end, rst_drive, sd_oe_hi, sd_oe_lo, dma_preempted, dma_resumed;
  icd_sd_type sd_out;
  logic [7:0] dack, dreq;
  logic [2:0] timer_tick;
  int error_cnt = 0;
  int n_compared = 0;
  int n_pre = 0;
  int n_res = 0;
  int ticks [3] = '{0, 0, 0};
  int n;
  icd_top #(.RELOAD(16'h0007)) dut_u (.clock(clock), .resetn(resetn), .osc_clock(osc_clock),
    .cycle_req(cycle_req), .zero_wait_n(zero_wait_n), .chan_ready(chan_ready), .cycle_end(cycle_end),
    .pci_bus_reset_in(pci_bus_reset_in), .clk_div_reset(clk_div_reset), .rst_drive(rst_drive),
    .sd_data(sd_data), .drive_hi(drive_hi), .drive_lo(drive_lo), .sd_out(sd_out), .sd_oe_hi(sd_oe_hi),
    .sd_oe_lo(sd_oe_lo), .dma_cfg(dma_cfg), .dreq(dreq), .dack(dack), .dma_preempted(dma_preempted),
    .dma_resumed(dma_resumed), .timer_tick(timer_tick));
  icd_dma_peer peer_u (.clock(clock), .want(want), .io_cmd(io_cmd), .dma_cfg(dma_cfg), .dack(dack), .dreq(dreq),
    .sel(sel), .owned(owned));
  initial
  begin
    forever #12.5 clock = ~clock;
  end
  initial
  begin
    #7;
    forever #80 osc_clock = ~osc_clock;
  end
  always @(posedge clock)
  begin
    n_pre += int'(dma_preempted === 1'b1);
    n_res += int'(dma_resumed === 1'b1);
    for (int i = 0; i < 3; i++) ticks[i] += int'(timer_tick[i] === 1'b1);
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic stop_test();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // One bus cycle; zw low asks zero wait, rdy_low stalls the first clock
  task automatic cyc(input icd_kind_type kind, input logic zw, input logic rdy_low, output int cnt);
    cycle_req = '{1'b1, kind};
    step(1);
    cycle_req.start = 1'b0;
    // zero wait only once the cycle is decoded
    zero_wait_n = zw;
    chan_ready = ~rdy_low;
    cnt = 0;
    while (cycle_end !== 1'b1 && cnt < 20)
    begin
      step(1);
      cnt++;
      chan_ready = 1'b1;
    end
    zero_wait_n = 1'b1;
    step(1);
  endtask
  // Waits for the given channels active, in the configured polarity
  task automatic wait_dack(input logic [7:0] a);
    logic [7:0] raw;
    raw = dma_cfg.ack_high ? a : ~a;
    for (int k = 0; k < 40 && dack !== raw; k++) step(1);
    check(dack, raw);
  endtask
  initial
  begin
    step(20);
    check(dack, 8'hff);
    resetn = 1'b1;
    cyc(ICD_MEM16, 1'b0, 1'b0, n); check(16'(n), 2);
    cyc(ICD_MEM8, 1'b0, 1'b0, n); check(16'(n), 3);
    cyc(ICD_IO8, 1'b0, 1'b0, n); check(16'(n), 3);
    cyc(ICD_MEM8, 1'b1, 1'b0, n); check(16'(n), 6);
    cyc(ICD_IO16, 1'b0, 1'b0, n); check(16'(n), 3);
    cyc(ICD_MEM16, 1'b0, 1'b1, n); check(16'(n > 2), 1);
    sd_data = '{8'ha5, 8'h3c};
    drive_hi = 1'b1;
    step(1);
    check(sd_out, 16'ha53c);
    check({sd_oe_hi, sd_oe_lo}, 2'b10);
    clk_div_reset = 1'b1;
    step(1);
    check({rst_drive, sd_oe_hi}, 2'b10);
    // software holds reset drive past 1 us
    step(41);
    clk_div_reset = 1'b0;
    step(2);
    check(rst_drive, 1'b0);
    pci_bus_reset_in = 1'b1;
    step(4);
    check({rst_drive, sd_oe_hi, dack}, {2'b10, 8'hff});
    pci_bus_reset_in = 1'b0;
    drive_hi = 1'b0;
    step(6);
    for (int p = 0; p < 4; p++)
    begin
      dma_cfg = '{p[0], p[1], 1'b1};
      step(10);
      want = 8'h02;
      wait_dack(8'h02);
      io_cmd = 1'b1;
      step(1);
      check({sel, owned}, 16'h0202);
      io_cmd = 1'b0;
      want = 8'h00;
      wait_dack(8'h00);
    end
    dma_cfg = '{1'b0, 1'b0, 1'b1};
    step(10);
    want = 8'h10;
    step(20);
    check(dack, 8'hff);
    want = 8'h12;
    wait_dack(8'h02);
    want = 8'h13;
    step(200);
    check({dack, 8'(n_pre)}, {8'hfd, 8'h00});
    want = 8'h11;
    wait_dack(8'h01);
    want = 8'h10;
    wait_dack(8'h00);
    dma_cfg.compat = 1'b0;
    step(2);
    want = 8'h12;
    wait_dack(8'h02);
    want = 8'h13;
    step(150);
    check(dack, 8'hfd);
    wait_dack(8'h01);
    check(16'(n_pre), 1);
    want = 8'h12;
    wait_dack(8'h02);
    step(2);
    check(16'(n_res), 1);
    want = 8'h10;
    wait_dack(8'h00);
    ticks = '{0, 0, 0};
    step(2048);
    for (int i = 0; i < 3; i++) check(16'(ticks[i] >= 39 && ticks[i] <= 41), 1);
    stop_test();
  end
  initial
  begin
    #300000;
    error_cnt++;
    stop_test();
  end
endmodule // icd_top_test
